/* File: src/ake_alarm_cfg.sv */
// Added by the designer: the APB register port and the placing of the registers.
`timescale 1ns/1ps
module ake_alarm_cfg (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// keypad, levels while held; menu_exit is a one-cycle pulse
	input wire logic key_cursor,
	input wire logic key_inc,
	input wire logic key_dec,
	input wire logic key_confirm,
	input wire logic menu_enter,
	output logic menu_exit,
	// display
	output logic disp_active,
	output logic disp_edit,
	output logic [3:0] disp_page,
	output logic [2:0] disp_cursor,
	output logic [19:0] disp_digits,
	output logic backlight_flash,
	// alarm channels and outputs
	input wire logic [15:0] chan_trig,
	input wire logic [3:0] energy_tick,
	output logic alarm_out_1,
	output logic alarm_out_2,
	output logic alarm_out_3,
	output logic alarm_out_4
);
	ake_conv_if conv ();

	ake_pkg::ake_state_t state_q, state_d;
	logic [ake_pkg::CTRL_W-1:0] ctrl_q, ctrl_d;
	logic [15:0] chan_q, chan_d;
	logic [7:0] rel_q, rel_d;
	logic [15:0] route_q [ake_pkg::NUM_OUT];
	logic [15:0] route_d [ake_pkg::NUM_OUT];
	logic [3:0] page_q, page_d;
	logic [2:0] cur_q, cur_d;
	logic [19:0] dig_q, dig_d;
	logic [4:0] key_q;
	logic exit_q;
	logic [31:0] prdata_q;
	logic [31:0] rd_mux;
	logic rd_hit;
	logic [3:0] out_q, out_d;
	logic flash_q;
	logic disp_act_q, disp_edit_q;
	logic [3:0] disp_page_q;
	logic [2:0] disp_cur_q;
	logic [19:0] disp_dig_q;
	logic [16:0] sum;

	// key edges; one action per press, confirm wins over the others
	wire p_cur = key_cursor & ~key_q[0];
	wire p_inc = key_inc & ~key_q[1];
	wire p_dec = key_dec & ~key_q[2];
	wire p_conf = key_confirm & ~key_q[3];
	wire p_menu = menu_enter & ~key_q[4];
	wire k_conf = p_conf;
	wire k_cur = p_cur & ~p_conf;
	wire k_inc = p_inc & ~p_conf & ~p_cur;
	wire k_dec = p_dec & ~p_conf & ~p_cur & ~p_inc;
	wire browsing = state_q == ake_pkg::AKE_BROWSE;
	wire editing = state_q == ake_pkg::AKE_EDIT;

	// page classification
	wire pg_flag = page_q == ake_pkg::PG_EN || page_q == ake_pkg::PG_CUE
		|| page_q >= ake_pkg::PG_MODE0;
	wire pg_route = page_q >= ake_pkg::PG_ROUTE0 && page_q < ake_pkg::PG_MODE0;
	wire [1:0] pg_out = page_q[1:0];
	wire [2:0] ndig = pg_flag ? ake_pkg::DIG_FLAG
		: (page_q == ake_pkg::PG_REL) ? ake_pkg::DIG_REL : ake_pkg::DIG_MASK;
	wire [16:0] page_max = pg_flag ? ake_pkg::MAX_FLAG
		: (page_q == ake_pkg::PG_REL) ? ake_pkg::MAX_REL : ake_pkg::MAX_MASK;
	wire [2:0] flag_idx = (page_q == ake_pkg::PG_EN) ? 3'(ake_pkg::CTRL_EN_BIT)
		: (page_q == ake_pkg::PG_CUE) ? 3'(ake_pkg::CTRL_CUE_BIT)
		: 3'(ake_pkg::CTRL_MODE_LSB) + {1'b0, pg_out};
	wire [15:0] page_val = pg_flag ? {15'h0000, ctrl_q[flag_idx]}
		: (page_q == ake_pkg::PG_CHAN) ? chan_q
		: (page_q == ake_pkg::PG_REL) ? {8'h00, rel_q} : route_q[pg_out];

	assign conv.bin = page_val;

	ake_bin2dec u_conv (
		.c(conv)
	);

	// decimal edit buffer back to binary
	always_comb
	begin
		sum = 17'h00000;
		for (int d = 0; d < ake_pkg::NUM_DIG; d++)
			sum = sum + 17'(dig_q[d*ake_pkg::DIG_W +: ake_pkg::DIG_W] * ake_pkg::DIG_WEIGHT[d]);
	end

	wire commit_ok = sum <= page_max; // R20
	wire kp_commit = editing & k_conf & commit_ok; // R7 R20
	wire [3:0] sel_dig = dig_q[cur_q*ake_pkg::DIG_W +: ake_pkg::DIG_W];
	wire [3:0] dig_up = (sel_dig >= ake_pkg::DEC_TOP) ? 4'h0 : sel_dig + 4'h1; // R6
	wire [3:0] dig_dn = (sel_dig == 4'h0) ? ake_pkg::DEC_TOP : sel_dig - 4'h1; // R6

	// keypad state machine
	always_comb
	begin
		state_d = state_q;
		page_d = page_q;
		cur_d = cur_q;
		dig_d = dig_q;
		case (state_q)
			ake_pkg::AKE_IDLE:
			begin
				if (p_menu)
				begin
					state_d = ake_pkg::AKE_BROWSE;
					page_d = ake_pkg::PG_EN;
				end
			end
			ake_pkg::AKE_BROWSE:
			begin
				if (k_conf)
				begin
					state_d = ake_pkg::AKE_EDIT; // R4
					dig_d = conv.dec;
					cur_d = ndig - 3'h1;
				end
				else if (k_cur)
					state_d = ake_pkg::AKE_IDLE; // R1
				else if (k_inc)
					page_d = (page_q == ake_pkg::PG_LAST) ? ake_pkg::PG_EN : page_q + 4'h1; // R2
				else if (k_dec)
					page_d = (page_q == ake_pkg::PG_EN) ? ake_pkg::PG_LAST : page_q - 4'h1; // R3
			end
			ake_pkg::AKE_EDIT:
			begin
				if (k_conf)
					state_d = ake_pkg::AKE_BROWSE; // R7
				else if (k_cur)
					cur_d = (cur_q == 3'h0) ? ndig - 3'h1 : cur_q - 3'h1; // R5
				else if (k_inc)
					dig_d[cur_q*ake_pkg::DIG_W +: ake_pkg::DIG_W] = dig_up; // R6
				else if (k_dec)
					dig_d[cur_q*ake_pkg::DIG_W +: ake_pkg::DIG_W] = dig_dn; // R6
			end
			default:
				state_d = ake_pkg::AKE_IDLE;
		endcase
	end

	// apb decode; bus writes take priority over a keypad commit in the same cycle
	wire apb_acc = psel & penable;
	wire apb_wr = apb_acc & pwrite;
	wire wr_ctrl = apb_wr && paddr == ake_pkg::OFF_CTRL;
	wire wr_chan = apb_wr && paddr == ake_pkg::OFF_CHAN;
	wire wr_rel = apb_wr && paddr == ake_pkg::OFF_REL;
	wire kp_flag = kp_commit & pg_flag;
	wire kp_chan = kp_commit && page_q == ake_pkg::PG_CHAN;
	wire kp_rel = kp_commit && page_q == ake_pkg::PG_REL;

	always_comb
	begin
		ctrl_d = ctrl_q;
		if (kp_flag)
			ctrl_d[flag_idx] = sum[0]; // R8 R9 R18
		if (wr_ctrl)
			ctrl_d = pwdata[ake_pkg::CTRL_W-1:0]; // R8 R9 R18
	end

	assign chan_d = wr_chan ? pwdata[15:0] : kp_chan ? sum[15:0] : chan_q; // R10 R11
	// upper byte is not stored, so it always reads zero
	assign rel_d = wr_rel ? pwdata[7:0] : kp_rel ? sum[7:0] : rel_q; // R13 R14

	// alarm evaluation
	wire alarm_en = ctrl_q[ake_pkg::CTRL_EN_BIT];
	wire [15:0] act = chan_trig & chan_q & {ake_pkg::NUM_CH{alarm_en}}; // R8 R10
	logic [15:0] eff;

	genvar k;
	generate
		for (k = 0; k < ake_pkg::NUM_REL; k++)
		begin : g_rel
			// relation k pairs channels 2k and 2k+1
			wire both = act[2*k] & act[2*k+1];
			assign eff[2*k] = rel_q[k] ? both : act[2*k]; // R12 R13
			assign eff[2*k+1] = rel_q[k] ? both : act[2*k+1]; // R12 R13
		end
		for (k = 0; k < ake_pkg::NUM_OUT; k++)
		begin : g_out
			// out 0-1 face the first module, 2-3 the second; same setup for all
			wire wr_route = apb_wr && paddr == ake_pkg::OFF_ROUTE0 + 8'(k) * ake_pkg::OFF_ROUTE_STEP;
			wire kp_route = kp_commit && pg_route && pg_out == 2'(k);
			wire alm_mode = ctrl_q[ake_pkg::CTRL_MODE_LSB+k];
			assign route_d[k] = wr_route ? pwdata[15:0]
				: kp_route ? sum[15:0] : route_q[k]; // R15 R17
			assign out_d[k] = alm_mode ? |(eff & route_q[k]) : energy_tick[k]; // R16 R18 R19
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
					route_q[k] <= ake_pkg::RST_MASK;
				else
					route_q[k] <= route_d[k];
			end
		end
	endgenerate

	// register read side
	always_comb
	begin
		rd_mux = 32'h00000000;
		rd_hit = 1'b1;
		if (paddr == ake_pkg::OFF_CTRL)
			rd_mux[ake_pkg::CTRL_W-1:0] = ctrl_q;
		else if (paddr == ake_pkg::OFF_CHAN)
			rd_mux[15:0] = chan_q;
		else if (paddr == ake_pkg::OFF_REL)
			rd_mux[7:0] = rel_q;
		else if (paddr >= ake_pkg::OFF_ROUTE0 && paddr < ake_pkg::OFF_STATUS && paddr[1:0] == 2'h0)
			rd_mux[15:0] = route_q[2'((paddr - ake_pkg::OFF_ROUTE0) >> 2)];
		else if (paddr == ake_pkg::OFF_STATUS)
		begin
			rd_mux[15:0] = eff;
			rd_mux[ake_pkg::ST_OUT_LSB +: ake_pkg::NUM_OUT] = out_q;
			rd_mux[ake_pkg::ST_EDIT_BIT] = editing;
			rd_mux[ake_pkg::ST_BROWSE_BIT] = browsing;
			rd_mux[ake_pkg::ST_PAGE_LSB +: 4] = page_q;
		end
		else
			rd_hit = 1'b0;
	end

	wire ro_write = pwrite && paddr == ake_pkg::OFF_STATUS;
	assign pready = 1'b1;
	assign pslverr = apb_acc & (~rd_hit | ro_write);
	assign prdata = prdata_q;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata_q <= 32'h00000000;
		else if (psel & ~penable & ~pwrite)
			prdata_q <= rd_mux;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_q <= ake_pkg::RST_CTRL;
			chan_q <= ake_pkg::RST_MASK;
			rel_q <= ake_pkg::RST_REL;
		end
		else
		begin
			ctrl_q <= ctrl_d;
			chan_q <= chan_d;
			rel_q <= rel_d;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_q <= ake_pkg::AKE_IDLE;
			page_q <= ake_pkg::PG_EN;
			cur_q <= 3'h0;
			dig_q <= 20'h00000;
			key_q <= 5'h00;
			exit_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			page_q <= page_d;
			cur_q <= cur_d;
			dig_q <= dig_d;
			key_q <= {menu_enter, key_confirm, key_dec, key_inc, key_cursor};
			exit_q <= browsing & k_cur; // R1
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			out_q <= 4'h0;
			flash_q <= 1'b0;
			disp_act_q <= 1'b0;
			disp_edit_q <= 1'b0;
			disp_page_q <= 4'h0;
			disp_cur_q <= 3'h0;
			disp_dig_q <= 20'h00000;
		end
		else
		begin
			out_q <= out_d;
			flash_q <= ctrl_q[ake_pkg::CTRL_CUE_BIT] & |eff; // R9
			disp_act_q <= state_q != ake_pkg::AKE_IDLE;
			disp_edit_q <= editing;
			disp_page_q <= page_q;
			disp_cur_q <= cur_q;
			disp_dig_q <= editing ? dig_q : conv.dec; // R11 R14
		end
	end

	assign menu_exit = exit_q;
	assign backlight_flash = flash_q;
	assign disp_active = disp_act_q;
	assign disp_edit = disp_edit_q;
	assign disp_page = disp_page_q;
	assign disp_cursor = disp_cur_q;
	assign disp_digits = disp_dig_q;
	assign alarm_out_1 = out_q[0];
	assign alarm_out_2 = out_q[1];
	assign alarm_out_3 = out_q[2];
	assign alarm_out_4 = out_q[3];

	page_fwd_a: assert property (@(posedge pclk) disable iff (!presetn) // R2
		browsing && k_inc && page_q == ake_pkg::PG_LAST |=> page_q == ake_pkg::PG_EN)
		else $error("page did not wrap forward");
	page_back_a: assert property (@(posedge pclk) disable iff (!presetn) // R3
		browsing && k_dec |=> page_q == ($past(page_q) == ake_pkg::PG_EN ? ake_pkg::PG_LAST
			: $past(page_q) - 4'h1))
		else $error("page did not step back");
	menu_leave_a: assert property (@(posedge pclk) disable iff (!presetn) // R1
		browsing && k_cur |=> state_q == ake_pkg::AKE_IDLE && menu_exit ##1 !menu_exit)
		else $error("cursor did not leave alarm pages");
	edit_enter_a: assert property (@(posedge pclk) disable iff (!presetn) // R4
		browsing && k_conf |=> editing && cur_q == $past(ndig) - 3'h1)
		else $error("confirm did not enter edit");
	cursor_wrap_a: assert property (@(posedge pclk) disable iff (!presetn) // R5
		editing && k_cur && cur_q == 3'h0 |=> cur_q == ndig - 3'h1)
		else $error("cursor did not wrap");
	edit_commit_a: assert property (@(posedge pclk) disable iff (!presetn) // R7
		editing && k_conf && commit_ok && !apb_wr && page_q == ake_pkg::PG_CHAN
		|=> browsing && chan_q == $past(sum[15:0]))
		else $error("commit not stored");
	commit_reject_a: assert property (@(posedge pclk) disable iff (!presetn) // R20
		editing && k_conf && !commit_ok && !apb_wr
		|=> $stable(ctrl_q) && $stable(chan_q) && $stable(rel_q) && browsing)
		else $error("over-range value stored");
	alarm_off_a: assert property (@(posedge pclk) disable iff (!presetn) // R8
		!alarm_en && ctrl_q[ake_pkg::CTRL_MODE_LSB] |=> !alarm_out_1)
		else $error("alarm output while disabled");
	and_pair_a: assert property (@(posedge pclk) disable iff (!presetn) // R12
		alarm_en && rel_q[0] && ctrl_q[ake_pkg::CTRL_MODE_LSB] && route_q[0] == 16'h0001
		&& !(chan_trig[0] && chan_trig[1]) |=> !alarm_out_1)
		else $error("paired alarm fired with one channel");
	flash_off_a: assert property (@(posedge pclk) disable iff (!presetn) // R9
		!ctrl_q[ake_pkg::CTRL_CUE_BIT] |=> !backlight_flash)
		else $error("backlight flashing with cue off");
endmodule // ake_alarm_cfg

/* File: src/ake_bin2dec.sv */
`timescale 1ns/1ps
module ake_bin2dec (
	// conversion carrier
	ake_conv_if.cnv c
);
	localparam int SH_W = ake_pkg::NUM_CH + ake_pkg::NUM_DIG * ake_pkg::DIG_W;
	logic [SH_W-1:0] sh;

	// shift-add-3, purely combinational, so the display lags a stored value by one cycle only
	always_comb
	begin
		sh = {{(SH_W-ake_pkg::NUM_CH){1'b0}}, c.bin};
		for (int i = 0; i < ake_pkg::NUM_CH; i++)
		begin
			for (int d = 0; d < ake_pkg::NUM_DIG; d++)
			begin
				if (sh[ake_pkg::NUM_CH+d*ake_pkg::DIG_W +: ake_pkg::DIG_W] >= ake_pkg::BCD_ADJ_MIN)
					sh[ake_pkg::NUM_CH+d*ake_pkg::DIG_W +: ake_pkg::DIG_W] =
						sh[ake_pkg::NUM_CH+d*ake_pkg::DIG_W +: ake_pkg::DIG_W] + ake_pkg::BCD_ADJ;
			end
			sh = {sh[SH_W-2:0], 1'b0};
		end
	end

	assign c.dec = sh[SH_W-1:ake_pkg::NUM_CH]; // R11
endmodule // ake_bin2dec

/* File: src/ake_conv_if.sv */
`timescale 1ns/1ps
interface ake_conv_if;
	logic [15:0] bin;
	logic [19:0] dec;
	modport src (output bin, input dec);
	modport cnv (input bin, output dec);
endinterface

/* File: src/ake_pkg.sv */
// Functional notes
// R1: cursor key while browsing leaves alarm pages
// R2: increment key steps page forward, wraps
// R3: minus key steps page backward, wraps
// R4: confirm key enters edit of shown page
// R5: cursor key moves to next digit
// R6: increment raises digit, minus lowers digit
// R7: confirm commits value, returns to browsing
// R8: global yes/no enable gates alarm processing
// R9: cue option flashes backlight on alarm
// R10: sixteen channels, one enable bit each
// R11: channel mask edited as decimal 00000-65535
// R12: AND pair alarms only if both trigger
// R13: eight AND enables in low byte
// R14: relation byte edited as decimal 000-255
// R15: per-output sixteen-bit channel route mask
// R16: outputs 1-2 first module, 3-4 second
// R17: outputs 2-4 configured like output 1
// R18: per-output mode, alarm or energy tick
// R19: alarm output fires on routed enabled alarm
// R20: over-range edit rejected, old value kept
package ake_pkg;
	localparam int NUM_CH = 16;
	localparam int NUM_REL = 8;
	localparam int NUM_OUT = 4;
	localparam int NUM_DIG = 5;
	localparam int DIG_W = 4;
	localparam int CTRL_W = 6;
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_CHAN = 8'h04;
	localparam logic [7:0] OFF_REL = 8'h08;
	localparam logic [7:0] OFF_ROUTE0 = 8'h0C;
	localparam logic [7:0] OFF_ROUTE_STEP = 8'h04;
	localparam logic [7:0] OFF_STATUS = 8'h1C;
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_CUE_BIT = 1;
	localparam int CTRL_MODE_LSB = 2;
	localparam int ST_OUT_LSB = 16;
	localparam int ST_EDIT_BIT = 20;
	localparam int ST_BROWSE_BIT = 21;
	localparam int ST_PAGE_LSB = 24;
	localparam logic [3:0] PG_EN = 4'h0;
	localparam logic [3:0] PG_CUE = 4'h1;
	localparam logic [3:0] PG_CHAN = 4'h2;
	localparam logic [3:0] PG_REL = 4'h3;
	localparam logic [3:0] PG_ROUTE0 = 4'h4;
	localparam logic [3:0] PG_MODE0 = 4'h8;
	localparam logic [3:0] PG_LAST = 4'hB;
	localparam logic [16:0] MAX_MASK = 17'h0FFFF;
	localparam logic [16:0] MAX_REL = 17'h000FF;
	localparam logic [16:0] MAX_FLAG = 17'h00001;
	localparam logic [2:0] DIG_MASK = 3'h5;
	localparam logic [2:0] DIG_REL = 3'h3;
	localparam logic [2:0] DIG_FLAG = 3'h1;
	localparam logic [3:0] DEC_TOP = 4'h9;
	localparam logic [3:0] BCD_ADJ_MIN = 4'h5;
	localparam logic [3:0] BCD_ADJ = 4'h3;
	localparam logic [16:0] DIG_WEIGHT [NUM_DIG] = '{17'h00001, 17'h0000A, 17'h00064,
		17'h003E8, 17'h02710};
	localparam logic [CTRL_W-1:0] RST_CTRL = 6'h3C;
	localparam logic [15:0] RST_MASK = 16'h0000;
	localparam logic [7:0] RST_REL = 8'h00;
	typedef enum logic [1:0] {AKE_IDLE, AKE_BROWSE, AKE_EDIT} ake_state_t;
endpackage

/* File: src/README_unused.sv */
`timescale 1ns/1ps

/* File: tb/ake_alarm_cfg_bench.sv */
`timescale 1ns/1ps
module ake_alarm_cfg_bench;
	localparam int K_CUR = 0;
	localparam int K_INC = 1;
	localparam int K_DEC = 2;
	localparam int K_OK = 3;
	localparam int K_MENU = 4;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic key_cursor, key_inc, key_dec, key_confirm, menu_enter, menu_exit;
	logic disp_active, disp_edit, backlight_flash;
	logic [3:0] disp_page;
	logic [2:0] disp_cursor;
	logic [19:0] disp_digits;
	logic [15:0] chan_trig = 16'h0000;
	logic [3:0] energy_tick = 4'h0;
	logic alarm_out_1, alarm_out_2, alarm_out_3, alarm_out_4;
	logic [31:0] q;
	logic err;
	int fail_count = 0;
	int check_count = 0;

	ake_alarm_cfg i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .key_cursor(key_cursor), .key_inc(key_inc), .key_dec(key_dec),
		.key_confirm(key_confirm), .menu_enter(menu_enter), .menu_exit(menu_exit),
		.disp_active(disp_active), .disp_edit(disp_edit), .disp_page(disp_page),
		.disp_cursor(disp_cursor), .disp_digits(disp_digits),
		.backlight_flash(backlight_flash), .chan_trig(chan_trig), .energy_tick(energy_tick),
		.alarm_out_1(alarm_out_1), .alarm_out_2(alarm_out_2), .alarm_out_3(alarm_out_3),
		.alarm_out_4(alarm_out_4));

	ake_keypad_model kp (.pclk(pclk), .key_cursor(key_cursor), .key_inc(key_inc),
		.key_dec(key_dec), .key_confirm(key_confirm), .menu_enter(menu_enter),
		.menu_exit(menu_exit));

	initial
	begin
		forever #12.5 pclk = ~pclk;
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp)
		begin
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
			fail_count++;
		end
	endtask

	// request held until pready is sampled high; data taken at that same edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		penable <= 1'b0;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50)
			chk("pready", 32'h1, 32'h0);
	endtask

	task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h00000000);
		chk(what, exp, q);
	endtask

	task automatic outs_chk(input string what, input logic [3:0] exp);
		repeat (3) @(posedge pclk);
		chk(what, {28'h0000000, exp}, {28'h0000000, alarm_out_4, alarm_out_3, alarm_out_2,
			alarm_out_1});
	endtask

	task automatic disp_chk(input logic ed, input logic [3:0] pg, input logic [2:0] cur);
		chk("disp_edit", {31'h0, ed}, {31'h0, disp_edit});
		chk("disp_page", {28'h0, pg}, {28'h0, disp_page});
		if (ed)
			chk("disp_cursor", {29'h0, cur}, {29'h0, disp_cursor});
	endtask

	task automatic report_and_stop;
		if (fail_count == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	initial
	begin
		repeat (20000) @(posedge pclk);
		fail_count++;
		report_and_stop;
	end

	initial
	begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		rd_chk("ctrl", ake_pkg::OFF_CTRL, 32'h0000003C);
		chk("ctrl err", 32'h0, {31'h0, err});
		rd_chk("chan", ake_pkg::OFF_CHAN, 32'h00000000);
		rd_chk("rel", ake_pkg::OFF_REL, 32'h00000000);
		for (int k = 0; k < 4; k++)
			rd_chk("route", ake_pkg::OFF_ROUTE0 + 8'(4 * k), 32'h00000000);
		apb(1'b0, 8'h40, 32'h00000000);
		chk("unmapped err", 32'h1, {31'h0, err});
		chk("unmapped data", 32'h0, q);
		apb(1'b1, ake_pkg::OFF_STATUS, 32'hFFFFFFFF);
		chk("status write err", 32'h1, {31'h0, err});
		apb(1'b1, ake_pkg::OFF_CHAN, 32'h0000FFFF);
		rd_chk("chan", ake_pkg::OFF_CHAN, 32'h0000FFFF);
		apb(1'b1, ake_pkg::OFF_REL, 32'h000001FF);
		rd_chk("rel", ake_pkg::OFF_REL, 32'h000000FF);
		apb(1'b1, ake_pkg::OFF_REL, 32'h00000000);
		apb(1'b1, ake_pkg::OFF_CTRL, 32'h0000003D);
		// each output routed to its own channel only
		for (int k = 0; k < 4; k++)
			apb(1'b1, ake_pkg::OFF_ROUTE0 + 8'(4 * k), 32'(1 << k));
		for (int k = 0; k < 4; k++)
		begin
			chan_trig <= 16'(1 << k);
			outs_chk("route", 4'(1 << k));
		end
		rd_chk("status idle", ake_pkg::OFF_STATUS, 32'h00080008);
		chan_trig <= 16'h000F;
		apb(1'b1, ake_pkg::OFF_CTRL, 32'h0000003C);
		outs_chk("global off", 4'h0);
		apb(1'b1, ake_pkg::OFF_CTRL, 32'h0000003F);
		repeat (3) @(posedge pclk);
		chk("flash", 32'h1, {31'h0, backlight_flash});
		apb(1'b1, ake_pkg::OFF_CTRL, 32'h0000003D);
		repeat (3) @(posedge pclk);
		chk("no flash", 32'h0, {31'h0, backlight_flash});
		apb(1'b1, ake_pkg::OFF_REL, 32'h00000001);
		chan_trig <= 16'h0001;
		outs_chk("and one", 4'h0);
		chan_trig <= 16'h0003;
		outs_chk("and both", 4'h3);
		apb(1'b1, ake_pkg::OFF_REL, 32'h000000FF);
		apb(1'b1, ake_pkg::OFF_CTRL, 32'h00000039);
		chan_trig <= 16'h0000;
		energy_tick <= 4'h1;
		outs_chk("energy tick", 4'h1);
		energy_tick <= 4'h0;
		chan_trig <= 16'h0001;
		outs_chk("energy no alarm", 4'h0);
		kp.press(K_MENU);
		chk("active", 32'h1, {31'h0, disp_active});
		disp_chk(1'b0, 4'h0, 3'h0);
		kp.press(K_DEC);
		disp_chk(1'b0, 4'hB, 3'h0);
		kp.press(K_INC);
		disp_chk(1'b0, 4'h0, 3'h0);
		kp.press(K_INC);
		kp.press(K_INC);
		rd_chk("status browse", ake_pkg::OFF_STATUS, 32'h02200000);
		kp.press(K_OK);
		disp_chk(1'b1, 4'h2, 3'h4);
		chk("digits", 32'h00065535, {12'h0, disp_digits});
		kp.press(K_DEC);
		chk("digits dec", 32'h00055535, {12'h0, disp_digits});
		kp.press(K_OK);
		disp_chk(1'b0, 4'h2, 3'h0);
		rd_chk("chan commit", ake_pkg::OFF_CHAN, 32'h0000D8EF);
		kp.press(K_OK);
		kp.press(K_INC);
		chk("digits inc", 32'h00065535, {12'h0, disp_digits});
		kp.press(K_CUR);
		disp_chk(1'b1, 4'h2, 3'h3);
		kp.press(K_INC);
		chk("digits over", 32'h00066535, {12'h0, disp_digits});
		kp.press(K_OK);
		rd_chk("chan kept", ake_pkg::OFF_CHAN, 32'h0000D8EF);
		kp.press(K_INC);
		chk("rel browse digits", 32'h00000255, {12'h0, disp_digits});
		kp.press(K_OK);
		disp_chk(1'b1, 4'h3, 3'h2);
		chk("rel digits", 32'h00000255, {12'h0, disp_digits});
		kp.press(K_CUR);
		kp.press(K_CUR);
		disp_chk(1'b1, 4'h3, 3'h0);
		kp.press(K_CUR);
		disp_chk(1'b1, 4'h3, 3'h2);
		kp.press(K_OK);
		kp.press(K_CUR);
		chk("exit pulses", 32'h1, 32'(kp.exit_seen));
		chk("left pages", 32'h0, {31'h0, disp_active});
		// mid-run reset must bring control, channel mask and relation byte back to their defaults
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rd_chk("ctrl reset", ake_pkg::OFF_CTRL, 32'(ake_pkg::RST_CTRL));
		rd_chk("chan reset", ake_pkg::OFF_CHAN, 32'(ake_pkg::RST_MASK));
		rd_chk("rel reset", ake_pkg::OFF_REL, 32'(ake_pkg::RST_REL));
		report_and_stop;
	end
endmodule // ake_alarm_cfg_bench

/* File: tb/ake_keypad_model.sv */
`timescale 1ns/1ps
module ake_keypad_model (
	// clock
	input wire logic pclk,
	// keys toward the block
	output logic key_cursor,
	output logic key_inc,
	output logic key_dec,
	output logic key_confirm,
	output logic menu_enter,
	// display side
	input wire logic menu_exit
);
	logic [4:0] key_q = 5'h00;
	int exit_seen = 0;
	assign key_cursor = key_q[0];
	assign key_inc = key_q[1];
	assign key_dec = key_q[2];
	assign key_confirm = key_q[3];
	assign menu_enter = key_q[4];
	// one press: level for one cycle, then released so the next press is a fresh edge
	task press(input int k);
		@(posedge pclk);
		key_q[k] <= 1'b1;
		@(posedge pclk);
		key_q[k] <= 1'b0;
		repeat (3) @(posedge pclk);
	endtask
	// exit is a one-cycle pulse, so it is counted at every edge
	always @(posedge pclk)
	begin
		if (menu_exit === 1'b1)
			exit_seen <= exit_seen + 1;
	end
endmodule // ake_keypad_model
